/* File: logic/oring_pkg.sv */
// Purpose: shared constants for the oring switch control block
// Assumes: 20 MHz ref_clk, avalon-mm byte addresses, 32-bit data
// Notes:   threshold tables are in mV or in tenths of a percent
package oring_pkg;

    // register byte addresses
    localparam logic [7:0] ADDR_SETTINGS = 8'h30;
    localparam logic [7:0] ADDR_STATUS   = 8'h34;

    // settings field positions
    localparam int ACC_THR_HI  = 7;
    localparam int ACC_THR_LO  = 6;
    localparam int EN_THR_HI   = 5;
    localparam int EN_THR_LO   = 4;
    localparam int FAST_THR_HI = 3;
    localparam int FAST_THR_LO = 2;
    localparam int FAST_DEB_B  = 1;
    localparam int FAST_BYP_B  = 0;

    // status field positions
    localparam int ST_SWITCH_B = 0;
    localparam int ST_ACC_B    = 1;
    localparam int ST_EN_B     = 2;
    localparam int ST_RAW_B    = 3;
    localparam int ST_TRIP_B   = 4;

    localparam logic [7:0] SETTINGS_RST = 8'h00;

    // accurate flag threshold, mV (code 00, reserved codes fall back to it)
    localparam int ACC_THR_MV = 0;

    // enable thresholds in tenths of a percent of adc full range
    localparam int EN_THR_0_PM = -5;
    localparam int EN_THR_1_PM = 0;
    localparam int EN_THR_2_PM = 10;
    localparam int EN_THR_3_PM = 20;
    localparam int PM_SCALE    = 1000;

    // fast turn-off thresholds, mV
    localparam int FAST_THR_0_MV = -100;
    localparam int FAST_THR_1_MV = -75;
    localparam int FAST_THR_2_MV = -50;
    localparam int FAST_THR_3_MV = -25;

    // debounce times, rounded up to whole clocks
    localparam int CLK_PERIOD_NS  = 50;
    localparam int DEB_SHORT_NS   = 40;
    localparam int DEB_LONG_NS    = 200;
    localparam int DEB_SHORT_CYC  = (DEB_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEB_LONG_CYC   = (DEB_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEB_CNT_W      = 4;

    typedef enum logic {
        SW_OFF,
        SW_ON
    } switch_state_e;

endpackage

/* File: logic/trip_debounce.sv */
// Purpose: counts consecutive fast comparator hits before a trip
// Assumes: raw is a same-clock registered comparator result
// Notes:   trip clears as soon as raw drops
module trip_debounce
    import oring_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    input  wire logic raw,
    input  wire logic long_sel,
    output logic      tripped
);

    logic [DEB_CNT_W-1:0] cnt;
    wire  [DEB_CNT_W-1:0] need     = long_sel ? DEB_CNT_W'(DEB_LONG_CYC)
                                              : DEB_CNT_W'(DEB_SHORT_CYC);
    wire  [DEB_CNT_W-1:0] cnt_inc  = (cnt == need) ? cnt : cnt + 1'b1;
    wire                  next_trip = raw && (cnt_inc >= need);

    // count stops at the target; it wraps only if long_sel drops while cnt is past the short target
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cnt     <= '0;
            tripped <= 1'b0;
        end else begin
            cnt     <= raw ? cnt_inc : '0;
            tripped <= next_trip;
        end
    end

endmodule // trip_debounce

/* File: logic/oring_switch_control.sv */
// Purpose: oring switch setting register and on/off decision logic
// Assumes: sense samples are produced by front-end logic on ref_clk
// Notes:   one avalon-mm slave with a single wait state per access
//
// the current sense input is the pos-minus-neg difference in mV; the
// voltage input is local minus remote sense, in adc codes.

// Functional notes
// - accurate flag sets when sense difference reaches field 7:6 threshold, 0 mV.
// - switch may turn on only while local minus remote exceeds field 5:4 threshold.
// - fast path turns off below -100, -75, -50 or -25 mV per field 3:2.
// - fast result is debounced 40 ns or 200 ns per bit 1 first.
// - bit 0 set bypasses fast turn-off; accurate path alone turns switch off.
module oring_switch_control
    import oring_pkg::*;
#(
    parameter int CS_W     = 9,
    parameter int VS_W     = 13,
    parameter int ADC_FULL = 4096
) (
    input  wire logic                   ref_clk,
    input  wire logic                   sys_rst,
    // avalon-mm slave
    input  wire logic [7:0]             address,
    input  wire logic                   read,
    input  wire logic                   write,
    input  wire logic [31:0]            writedata,
    input  wire logic [3:0]             byteenable,
    output logic      [31:0]            readdata,
    output logic                        waitrequest,
    // sense samples
    input  wire logic signed [CS_W-1:0] cs_diff_mv,
    input  wire logic signed [VS_W-1:0] vs_diff,
    // switch side
    output logic                        oring_switch,
    output logic                        accurate_flag
);

    // enable thresholds scaled to adc codes
    localparam int EN_TH0 = ADC_FULL * EN_THR_0_PM / PM_SCALE;
    localparam int EN_TH1 = ADC_FULL * EN_THR_1_PM / PM_SCALE;
    localparam int EN_TH2 = ADC_FULL * EN_THR_2_PM / PM_SCALE;
    localparam int EN_TH3 = ADC_FULL * EN_THR_3_PM / PM_SCALE;

    logic [7:0]    settings;
    logic          enable_ok;
    logic          fast_raw;
    logic          fast_trip;
    switch_state_e state;
    switch_state_e next_state;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------

    // waitrequest is high at rest; it drops for one cycle per request
    wire req        = read | write;
    wire bus_accept = req & waitrequest;
    wire bus_done   = req & ~waitrequest;
    wire hit_set    = (address == ADDR_SETTINGS);
    wire hit_stat   = (address == ADDR_STATUS);
    wire set_wr     = bus_done & write & hit_set & byteenable[0];

    wire [7:0] status_bits;
    assign status_bits[ST_SWITCH_B] = oring_switch;
    assign status_bits[ST_ACC_B]    = accurate_flag;
    assign status_bits[ST_EN_B]     = enable_ok;
    assign status_bits[ST_RAW_B]    = fast_raw;
    assign status_bits[ST_TRIP_B]   = fast_trip;
    assign status_bits[7:5]         = 3'h0;

    // unmapped addresses read as zero, writes to them are dropped
    wire [31:0] rd_mux = hit_set  ? {24'h000000, settings}    :
                         hit_stat ? {24'h000000, status_bits} :
                                    32'h00000000;

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------

    wire [1:0] acc_code  = settings[ACC_THR_HI:ACC_THR_LO];
    wire [1:0] en_code   = settings[EN_THR_HI:EN_THR_LO];
    wire [1:0] fast_code = settings[FAST_THR_HI:FAST_THR_LO];
    wire       deb_long  = settings[FAST_DEB_B];
    wire       fast_byp  = settings[FAST_BYP_B];

    // reserved codes are not guarded; they reuse the 0 mV level
    wire signed [CS_W-1:0] acc_thr = (acc_code == 2'h0) ? CS_W'(ACC_THR_MV)
                                                        : CS_W'(ACC_THR_MV);

    wire signed [VS_W-1:0] en_thr =
        (en_code == 2'h0) ? VS_W'(EN_TH0) :
        (en_code == 2'h1) ? VS_W'(EN_TH1) :
        (en_code == 2'h2) ? VS_W'(EN_TH2) :
                            VS_W'(EN_TH3);

    wire signed [CS_W-1:0] fast_thr =
        (fast_code == 2'h0) ? CS_W'(FAST_THR_0_MV) :
        (fast_code == 2'h1) ? CS_W'(FAST_THR_1_MV) :
        (fast_code == 2'h2) ? CS_W'(FAST_THR_2_MV) :
                              CS_W'(FAST_THR_3_MV);

    // ------------------------------------------------------------
    // comparisons
    // ------------------------------------------------------------

    wire next_acc     = (cs_diff_mv >= acc_thr);
    wire next_enable  = (vs_diff > en_thr);
    wire next_fastraw = (cs_diff_mv < fast_thr);

    // fast trip only acts when the bypass bit is clear
    wire fast_off = fast_trip & ~fast_byp;
    // with bypass, reverse current seen by the accurate path turns it off
    wire acc_off  = fast_byp & ~accurate_flag;

    // ------------------------------------------------------------
    // switch state
    // ------------------------------------------------------------

    always_comb begin
        next_state = state;
        case (state)
            SW_OFF: begin
                // a pending fast trip holds the switch off as well
                if (enable_ok && !fast_off) begin
                    next_state = SW_ON;
                end
            end
            SW_ON: begin
                if (fast_off || acc_off) begin
                    next_state = SW_OFF;
                end
            end
            default: begin
                next_state = SW_OFF;
            end
        endcase
    end

    // the fast comparator is debounced before it may turn off the switch
    trip_debounce u_trip_debounce (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .raw      (fast_raw),
        .long_sel (deb_long),
        .tripped  (fast_trip)
    );

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------

    // bus handshake: one wait state, read data loaded on acceptance
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            waitrequest <= 1'b1;
            readdata    <= 32'h00000000;
        end else begin
            waitrequest <= ~bus_accept;
            if (bus_accept && read) begin
                readdata <= rd_mux;
            end
        end
    end

    // setting register, only byte lane 0 carries bits
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            settings <= SETTINGS_RST;
        end else if (set_wr) begin
            settings <= writedata[7:0];
        end
    end

    // comparator results and switch drive
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            accurate_flag <= 1'b0;
            enable_ok     <= 1'b0;
            fast_raw      <= 1'b0;
            state         <= SW_OFF;
            oring_switch  <= 1'b0;
        end else begin
            accurate_flag <= next_acc;
            enable_ok     <= next_enable;
            fast_raw      <= next_fastraw;
            state         <= next_state;
            oring_switch  <= (next_state == SW_ON);
        end
    end

endmodule // oring_switch_control

/* File: dv/power_path_model.sv */
// Purpose: switch transistor and sense resistor seen from the block
// Assumes: bench sets the current it would carry and the sense voltages
// Notes:   an open switch carries no current, so the sense pair reads zero
module power_path_model #(
    parameter int CS_W = 9,
    parameter int VS_W = 13
) (
    input  wire logic                   oring_switch,
    input  wire logic signed [CS_W-1:0] cur_cmd,
    input  wire logic signed [VS_W-1:0] vs_cmd,
    output logic signed      [CS_W-1:0] cs_diff_mv,
    output logic signed      [VS_W-1:0] vs_diff
);
    timeunit 1ns;
    timeprecision 1ns;
    // no body diode modelled: a stricter far side than the real one
    assign cs_diff_mv = oring_switch ? cur_cmd : '0;
    assign vs_diff    = vs_cmd;
endmodule // power_path_model

/* File: dv/oring_switch_control_asserts.sv */
// Purpose: port-level checks of the switch decision logic
// Assumes: settings are tracked from completed bus writes
// Notes:   settings must not change while a trip is in flight
module oring_switch_control_asserts
    import oring_pkg::*;
#(
    parameter int CS_W     = 9,
    parameter int VS_W     = 13,
    parameter int ADC_FULL = 4096
) (
    input wire logic                   ref_clk,
    input wire logic                   sys_rst,
    input wire logic [7:0]             address,
    input wire logic                   read,
    input wire logic                   write,
    input wire logic [31:0]            writedata,
    input wire logic [3:0]             byteenable,
    input wire logic [31:0]            readdata,
    input wire logic                   waitrequest,
    input wire logic signed [CS_W-1:0] cs_diff_mv,
    input wire logic signed [VS_W-1:0] vs_diff,
    input wire logic                   oring_switch,
    input wire logic                   accurate_flag
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PM [4] = '{EN_THR_0_PM, EN_THR_1_PM, EN_THR_2_PM, EN_THR_3_PM};
    localparam int FT [4] = '{FAST_THR_0_MV, FAST_THR_1_MV, FAST_THR_2_MV, FAST_THR_3_MV};
    logic [7:0] shadow;
    logic       below;
    int         en_thr;
    // shadow copy of settings, taken at the completing edge only
    always_ff @(posedge ref_clk) begin
        if (sys_rst)
            shadow <= SETTINGS_RST;
        else if (write && !waitrequest && address == ADDR_SETTINGS && byteenable[0])
            shadow <= writedata[7:0];
    end
    assign below  = int'(cs_diff_mv) < FT[shadow[3:2]];
    assign en_thr = ADC_FULL * PM[shadow[5:4]] / PM_SCALE;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // reverse current past the fast level while the fast path is armed
    sequence hit_short_s;
        oring_switch && below && !shadow[0] && !shadow[1];
    endsequence
    sequence hit_long_s;
        (oring_switch && below && !shadow[0] && shadow[1])[*4];
    endsequence
    AST_ACC_FLAG: assert property (!$past(sys_rst) |->
        accurate_flag == ($past(cs_diff_mv) >= 0)) else $error("accurate flag wrong");
    AST_EN_ON: assert property ($rose(oring_switch) |->
        int'($past(vs_diff, 2)) > en_thr) else $error("switch on without enable");
    AST_FAST_SHORT: assert property (hit_short_s |-> ##3 !oring_switch)
        else $error("short trip late");
    AST_FAST_LONG: assert property (hit_long_s |-> ##3 !oring_switch)
        else $error("long trip late");
    AST_BYP_OFF: assert property (oring_switch && shadow[0] && !accurate_flag |=>
        !oring_switch) else $error("bypass off late");
    AST_RD_SET: assert property (read && !waitrequest && address == ADDR_SETTINGS |->
        readdata == {24'h0, shadow}) else $error("settings readback wrong");
endmodule // oring_switch_control_asserts

bind oring_switch_control oring_switch_control_asserts #(
    .CS_W(CS_W), .VS_W(VS_W), .ADC_FULL(ADC_FULL)
) u_chk (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .cs_diff_mv(cs_diff_mv),
    .vs_diff(vs_diff), .oring_switch(oring_switch), .accurate_flag(accurate_flag)
);

/* File: dv/oring_switch_control_bench.sv */
// Purpose: self-checking bench for the switch settings and decisions
// Assumes: one wait state per bus access, settings reset to zero
// Notes:   each row resets first; vs_cmd is held low so a tripped switch cannot re-enable
module oring_switch_control_bench import oring_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic               ref_clk, sys_rst, read, write, waitrequest, oring_switch;
    logic               accurate_flag;
    logic        [7:0]  address;
    logic        [31:0] writedata, readdata, q;
    logic        [3:0]  byteenable;
    logic signed [8:0]  cur_cmd, cs_diff_mv;
    logic signed [12:0] vs_cmd, vs_diff;
    int                 n_errors, n_tests;
    // enable threshold in codes, fast threshold in mV, edges until off
    int rows [4][3] = '{'{-20, -100, 3}, '{0, -75, 6}, '{40, -50, 3}, '{81, -25, 6}};
    oring_switch_control dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .cs_diff_mv(cs_diff_mv),
        .vs_diff(vs_diff), .oring_switch(oring_switch), .accurate_flag(accurate_flag));
    power_path_model far (.oring_switch(oring_switch), .cur_cmd(cur_cmd),
        .vs_cmd(vs_cmd), .cs_diff_mv(cs_diff_mv), .vs_diff(vs_diff));
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    task stop_test;
        $display("tests=%0d errors=%0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // request held until waitrequest is sampled low, then released
    task bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
        @(posedge ref_clk);
        read <= !w;
        write <= w;
        address <= a;
        writedata <= {24'h0, d};
        byteenable <= be;
        do @(posedge ref_clk); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task rst;
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (6) @(posedge ref_clk);
        chk(waitrequest, 1'b1);
        chk(oring_switch, 1'b0);
        chk(accurate_flag, 1'b0);
        sys_rst <= 1'b0;
    endtask
    task setin(input int c, input int v);
        @(posedge ref_clk);
        cur_cmd <= 9'(c);
        vs_cmd <= 13'(v);
    endtask
    // k edges on, look between edges: s picks the flag, else the switch
    task after(input int k, input logic s, input logic v);
        repeat (k) @(posedge ref_clk);
        if (k > 0) @(negedge ref_clk);
        chk(s ? accurate_flag : oring_switch, v);
    endtask
    initial begin
        sys_rst = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 8'h00;
        writedata = 32'h0;
        byteenable = 4'h0;
        cur_cmd = 9'h000;
        vs_cmd = -13'sd2000;
        rst;
        bus(0, ADDR_SETTINGS, 8'h00, 4'hf);
        chk(q, 32'h0);
        bus(1, ADDR_SETTINGS, 8'h3d, 4'h1);
        bus(1, ADDR_SETTINGS, 8'hff, 4'he);
        bus(0, ADDR_SETTINGS, 8'h00, 4'hf);
        chk(q, 32'h3d);
        bus(1, 8'h08, 8'hff, 4'hf);
        bus(0, 8'h08, 8'h00, 4'hf);
        chk(q, 32'h0);
        bus(0, ADDR_STATUS, 8'h00, 4'hf);
        chk(q, 32'h2);
        for (int i = 0; i < 4; i++) begin
            rst;
            bus(1, ADDR_SETTINGS, {2'b00, 2'(i), 2'(i), 1'(i), 1'b0}, 4'h1);
            setin(0, rows[i][0]);
            after(3, 0, 0);
            setin(0, rows[i][0] + 1);
            after(1, 0, 0);
            after(1, 0, 1);
            // switch on, enable seen, no reverse current: status shows bits 2:0
            bus(0, ADDR_STATUS, 8'h00, 4'hf);
            chk(q, 32'h7);
            setin(rows[i][1], -2000);
            after(6, 0, 1);
            setin(rows[i][1] - 1, -2000);
            after(rows[i][2] - 1, 0, 1);
            after(1, 0, 0);
        end
        // bypass with long debounce: only the accurate path may act
        rst;
        bus(1, ADDR_SETTINGS, 8'h13, 4'h1);
        setin(0, 1);
        after(2, 0, 1);
        setin(-120, -2000);
        after(1, 1, 0);
        after(0, 0, 1);
        after(1, 0, 0);
        after(1, 1, 1);
        stop_test;
    end
    // hang guard, well beyond the roughly 175 cycles the run needs
    initial begin
        repeat (3000) @(posedge ref_clk);
        n_errors++;
        stop_test;
    end
endmodule // oring_switch_control_bench
